// ### rtl/core_status_defines.svh
`ifndef CORE_STATUS_DEFINES_SVH
`define CORE_STATUS_DEFINES_SVH

// ==========================================
// Register offsets, word indices on the bus (address bits 9..2)
`define OFS_POINTER_LOW 8'h82
`define OFS_POINTER_HIGH 8'h83
`define OFS_POWER_CONTROL 8'h87
`define OFS_PROGRAM_STATUS 8'hD0
`define OFS_MAIN_OPERAND 8'hE0
`define OFS_MULTIPLY_AUX 8'hF0
`define OFS_CORE_OP 8'hF8
`define OFS_BIT_ACCESS 8'hF9
`define OFS_CORE_STATE 8'hFA
`define OFS_MEM_WINDOW 8'h00

// ==========================================
// Bit window
`define BIT_BYTE_BASE 8'h20
`define BIT_BYTE_LAST 8'h2F
`define BIT_ADDR_MAX 7'h7F

// ==========================================
// Field positions
`define STAT_CARRY 7
`define STAT_HALF 6
`define STAT_USER0 5
`define STAT_BANK_HI 4
`define STAT_BANK_LO 3
`define STAT_WRAP 2
`define STAT_USER1 1
`define STAT_PARITY 0
`define PWR_BAUD 7
`define PWR_STOP 1
`define PWR_IDLE 0
`define PWR_SOFT_MASK 8'h7C

// ==========================================
// Reset values
`define RST_POWER_CONTROL 8'h00
`define RST_PROGRAM_STATUS 8'h00
`define RST_PC 16'h0000

// ==========================================
// Timing
`define CLK_NS 4
`define LOST_CLOCK_US 100
`define LOST_CLOCK_CYCLES ((`LOST_CLOCK_US * 1000) / `CLK_NS)
`define RESET_SEQ_CYCLES 12

`endif

// ### rtl/core_status_pkg.sv
package core_status_pkg;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_ADD,
		OP_ADDC,
		OP_SUBB,
		OP_MUL,
		OP_DIV,
		OP_OTHER_ARITH
	} arith_op_type;

	typedef enum {
		ST_RESET_SEQ,
		ST_RUN,
		ST_IDLE,
		ST_STOP
	} power_state_type;
endpackage

// ### rtl/core_status_and_power_mode.sv
// Functional notes
// - Bytes 0x20..0x2F also reachable as 128 bits, addresses 0x00-0x7F.
// - Bit N maps to byte 0x20 + N/8, position N mod 8.
// - Bit or byte access chosen only by instruction operand type; byte writes to 0x20..0x2F ignored while 0xF9 bit 7 set.
// - Data pointer high byte at 0x83, low byte at 0x82.
// - Carry set on add carry or subtract borrow; else cleared.
// - Half carry set on nibble carry or borrow; else cleared.
// - Five soft flags in power bits 6..2, stored only.
// - Status bits 4..3 select one of four eight-byte register banks.
// - Wrap flag set on signed overflow, product above 255, divide by zero.
// - Wrap flag cleared by add, addc, subb, mul, div otherwise.
// - Status bit 0 is read-only odd parity of main operand.
// - Stop mode left only by reset.
// - After any reset, reset sequence then fetch from 0x0000.
// - Enabled lost clock detector resets out of stop after 100 us.
// - Power bit 7 doubles the serial baud rate.
// - Writing 1 to power bit 1 enters stop, oscillator off; the code enters stop only from run, not from idle or the reset sequence.
// - Stop request bit always reads 0.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "core_status_defines.svh"

module core_status_and_power_mode #(
	parameter int LOST_CLOCK_CYCLES = `LOST_CLOCK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic lost_clock_detector,
	input wire logic osc_alive,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic core_clk_en,
	output logic periph_clk_en,
	output logic osc_enable,
	output logic baud_doubler,
	output logic [1:0] bank_sel,
	output logic [4:0] bank_base,
	output logic [15:0] fetch_pc,
	output logic fetch_start,
	output logic lost_clock_reset
);

	// ==========================================
	// Functions
	function automatic logic parity8(input logic [7:0] v);
		parity8 = ^v;
	endfunction

	function automatic logic [3:0] bit_byte(input logic [6:0] n);
		bit_byte = n[6:3];
	endfunction

	// ==========================================
	// Storage
	logic [7:0] bit_mem_r [0:15];
	logic [7:0] pointer_low_byte_r, pointer_high_byte_r;
	logic [7:0] main_operand_r, multiply_aux_operand_r;
	logic carry_bit_r, half_carry_r, signed_wrap_flag_r;
	logic user_bit_zero_r, user_bit_one_r, bank_sel_hi_r, bank_sel_lo_r;
	logic baud_doubler_r;
	logic [4:0] spare_soft_flags_r;
	logic [2:0] core_op_r;
	logic [7:0] bit_ctl_r;
	core_status_pkg::power_state_type state_r, state_nxt;
	logic [$clog2(`RESET_SEQ_CYCLES+1)-1:0] seq_cnt_r;
	logic [31:0] lost_cnt_r;
	logic lost_fire_r;
	logic osc_s1_r, osc_s2_r, osc_s3_r;

	// ==========================================
	// Bus decode
	wire [7:0] adr = wb_adr_i[9:2];
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i & wb_sel_i[0];
	wire [7:0] wd = wb_dat_i[7:0];
	wire running = (state_r == core_status_pkg::ST_RUN);
	wire in_window = (adr >= `BIT_BYTE_BASE) && (adr <= `BIT_BYTE_LAST);
	wire [3:0] win_idx = 4'(adr - `BIT_BYTE_BASE);
	wire bit_op = bit_ctl_r[7];
	wire [6:0] bit_addr = bit_ctl_r[6:0];
	// Bit address to byte and position
	wire [3:0] b_byte = bit_byte(bit_addr);
	wire [2:0] b_pos = bit_addr[2:0];
	wire b_val = bit_mem_r[b_byte][b_pos];
	wire wr_bitctl = wr & (adr == `OFS_BIT_ACCESS);
	wire bit_write = wr_bitctl & wd[7] & wb_dat_i[8];
	// Bit write targets the address carried in the same word
	wire [3:0] w_byte = bit_byte(wd[6:0]);
	wire [2:0] w_pos = wd[2:0];

	// ==========================================
	// Arithmetic flag evaluation
	core_status_pkg::arith_op_type op;
	assign op = core_status_pkg::arith_op_type'(wd[2:0]);
	wire do_op = wr & (adr == `OFS_CORE_OP) & running;
	wire cin = (op == core_status_pkg::OP_ADDC) & carry_bit_r;
	wire [8:0] sum = {1'b0, main_operand_r} + {1'b0, multiply_aux_operand_r}
		+ {8'h00, cin};
	wire [4:0] hsum = {1'b0, main_operand_r[3:0]}
		+ {1'b0, multiply_aux_operand_r[3:0]} + {4'h0, cin};
	wire [8:0] dif = {1'b0, main_operand_r} - {1'b0, multiply_aux_operand_r}
		- {8'h00, carry_bit_r};
	wire [4:0] hdif = {1'b0, main_operand_r[3:0]}
		- {1'b0, multiply_aux_operand_r[3:0]} - {4'h0, carry_bit_r};
	wire [15:0] prod = main_operand_r * multiply_aux_operand_r;
	wire is_add = (op == core_status_pkg::OP_ADD) |
		(op == core_status_pkg::OP_ADDC);
	wire is_sub = (op == core_status_pkg::OP_SUBB);
	wire add_ovf = (main_operand_r[7] == multiply_aux_operand_r[7]) &
		(sum[7] != main_operand_r[7]);
	wire sub_ovf = (main_operand_r[7] != multiply_aux_operand_r[7]) &
		(dif[7] != main_operand_r[7]);
	wire wrap_nxt = is_add ? add_ovf : is_sub ? sub_ovf :
		(op == core_status_pkg::OP_MUL) ? (prod > 16'h00FF) :
		(op == core_status_pkg::OP_DIV) ? (multiply_aux_operand_r == 8'h00) :
		1'b0;
	wire wrap_touch = is_add | is_sub | (op == core_status_pkg::OP_MUL) |
		(op == core_status_pkg::OP_DIV);
	wire arith = wrap_touch | (op == core_status_pkg::OP_OTHER_ARITH);
	wire carry_nxt = is_add ? sum[8] : is_sub ? dif[8] : 1'b0;
	wire half_nxt = is_add ? hsum[4] : is_sub ? hdif[4] : 1'b0;

	// ==========================================
	// Register read data
	// Parity of main operand
	wire parity = parity8(main_operand_r);
	wire [7:0] status_rd = {carry_bit_r, half_carry_r, user_bit_zero_r,
		bank_sel_hi_r, bank_sel_lo_r, signed_wrap_flag_r, user_bit_one_r,
		parity};
	// Stop and idle bits read 0
	wire [7:0] power_rd = {baud_doubler_r, spare_soft_flags_r, 2'b00};
	logic [7:0] rd;
	always_comb begin
		case (adr)
			`OFS_POINTER_LOW: rd = pointer_low_byte_r;
			`OFS_POINTER_HIGH: rd = pointer_high_byte_r;
			`OFS_POWER_CONTROL: rd = power_rd;
			`OFS_PROGRAM_STATUS: rd = status_rd;
			`OFS_MAIN_OPERAND: rd = main_operand_r;
			`OFS_MULTIPLY_AUX: rd = multiply_aux_operand_r;
			`OFS_CORE_OP: rd = {5'h00, core_op_r};
			`OFS_BIT_ACCESS: rd = {7'h00, b_val};
			`OFS_CORE_STATE: rd = {6'h00, state_r == core_status_pkg::ST_STOP,
				state_r == core_status_pkg::ST_IDLE};
			default: rd = in_window ? bit_mem_r[win_idx] : 8'h00;
		endcase
	end

	// ==========================================
	// Bus slave
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= req ? {24'h000000, rd} : 32'h00000000;
		end
	end

	// ==========================================
	// Data registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pointer_low_byte_r <= 8'h00;
			pointer_high_byte_r <= 8'h00;
			main_operand_r <= 8'h00;
			multiply_aux_operand_r <= 8'h00;
			core_op_r <= 3'h0;
			bit_ctl_r <= 8'h00;
		end else if (wr) begin
			if (adr == `OFS_POINTER_LOW)
				pointer_low_byte_r <= wd;
			if (adr == `OFS_POINTER_HIGH)
				pointer_high_byte_r <= wd;
			if (adr == `OFS_MAIN_OPERAND)
				main_operand_r <= wd;
			if (adr == `OFS_MULTIPLY_AUX)
				multiply_aux_operand_r <= wd;
			if (adr == `OFS_CORE_OP)
				core_op_r <= wd[2:0];
			if (wr_bitctl)
				bit_ctl_r <= wd;
		end
	end

	// ==========================================
	// Bit addressable memory
	always_ff @(posedge clk_sys) begin
		if (wr & in_window & ~bit_op)
			bit_mem_r[win_idx] <= wd;
		else if (bit_write)
			bit_mem_r[w_byte][w_pos] <= wb_dat_i[9];
	end

	// ==========================================
	// Status flags
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{carry_bit_r, half_carry_r, user_bit_zero_r, bank_sel_hi_r,
				bank_sel_lo_r, signed_wrap_flag_r, user_bit_one_r} <= 7'h00;
		end else if (do_op & arith) begin
			carry_bit_r <= carry_nxt;
			half_carry_r <= half_nxt;
			// Wrap flag updated by its instructions
			if (wrap_touch)
				signed_wrap_flag_r <= wrap_nxt;
		end else if (wr & (adr == `OFS_PROGRAM_STATUS)) begin
			{carry_bit_r, half_carry_r, user_bit_zero_r, bank_sel_hi_r,
				bank_sel_lo_r, signed_wrap_flag_r, user_bit_one_r} <= wd[7:1];
		end
	end

	// ==========================================
	// Power control
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			baud_doubler_r <= 1'b0;
			spare_soft_flags_r <= 5'h00;
		end else if (wr & (adr == `OFS_POWER_CONTROL)) begin
			baud_doubler_r <= wd[`PWR_BAUD];
			spare_soft_flags_r <= wd[6:2];
		end
	end

	wire pwr_wr = wr & (adr == `OFS_POWER_CONTROL);
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			core_status_pkg::ST_RESET_SEQ:
				if (seq_cnt_r == `RESET_SEQ_CYCLES - 1)
					state_nxt = core_status_pkg::ST_RUN;
			core_status_pkg::ST_RUN: begin
				if (pwr_wr & wd[`PWR_STOP])
					state_nxt = core_status_pkg::ST_STOP;
				else if (pwr_wr & wd[`PWR_IDLE])
					state_nxt = core_status_pkg::ST_IDLE;
			end
			// Idle left by a power control write with bit 0 clear
			core_status_pkg::ST_IDLE:
				if (pwr_wr & ~wd[`PWR_IDLE])
					state_nxt = core_status_pkg::ST_RUN;
			core_status_pkg::ST_STOP: state_nxt = core_status_pkg::ST_STOP;
			default: state_nxt = core_status_pkg::ST_RESET_SEQ;
		endcase
	end

	// Reset sequence then fetch at zero
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= core_status_pkg::ST_RESET_SEQ;
			seq_cnt_r <= '0;
		end else if (lost_fire_r) begin
			state_r <= core_status_pkg::ST_RESET_SEQ;
			seq_cnt_r <= '0;
		end else begin
			state_r <= state_nxt;
			if (state_r == core_status_pkg::ST_RESET_SEQ)
				seq_cnt_r <= seq_cnt_r + 1'b1;
		end
	end

	// ==========================================
	// Lost clock detector
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end else begin
			osc_s1_r <= osc_alive;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end
	wire osc_dead = ~osc_s2_r & ~osc_s3_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lost_cnt_r <= 32'h00000000;
			lost_fire_r <= 1'b0;
		end else begin
			lost_fire_r <= 1'b0;
			if (!(lost_clock_detector && osc_dead &&
				state_r == core_status_pkg::ST_STOP))
				lost_cnt_r <= 32'h00000000;
			else if (lost_cnt_r >= 32'(LOST_CLOCK_CYCLES - 1)) begin
				lost_cnt_r <= 32'h00000000;
				lost_fire_r <= 1'b1;
			end else
				lost_cnt_r <= lost_cnt_r + 32'h00000001;
		end
	end

	// ==========================================
	// Outputs
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			core_clk_en <= 1'b0;
			periph_clk_en <= 1'b0;
			osc_enable <= 1'b1;
			baud_doubler <= 1'b0;
			bank_sel <= 2'b00;
			bank_base <= 5'h00;
			fetch_pc <= `RST_PC;
			fetch_start <= 1'b0;
			lost_clock_reset <= 1'b0;
		end else begin
			core_clk_en <= (state_nxt == core_status_pkg::ST_RUN);
			periph_clk_en <= (state_nxt != core_status_pkg::ST_STOP);
			osc_enable <= (state_nxt != core_status_pkg::ST_STOP);
			baud_doubler <= baud_doubler_r;
			bank_sel <= {bank_sel_hi_r, bank_sel_lo_r};
			bank_base <= {bank_sel_hi_r, bank_sel_lo_r, 3'b000};
			fetch_pc <= `RST_PC;
			fetch_start <= (state_r == core_status_pkg::ST_RESET_SEQ) &
				(state_nxt == core_status_pkg::ST_RUN) & ~lost_fire_r;
			lost_clock_reset <= lost_fire_r;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_stop_sticky: assert property (
		state_r == core_status_pkg::ST_STOP && !lost_fire_r
		|=> state_r == core_status_pkg::ST_STOP)
		else $error("stop left without reset");
	a_stop_reads_zero: assert property (
		wb_ack_o && $past(adr) == `OFS_POWER_CONTROL
		|-> wb_dat_o[1:0] == 2'b00)
		else $error("stop or idle bit read as one");
	a_parity_bit: assert property (
		wb_ack_o && $past(adr) == `OFS_PROGRAM_STATUS
		|-> wb_dat_o[0] == ^$past(main_operand_r))
		else $error("parity mismatch");
	a_carry_add: assert property (
		do_op && is_add |=> carry_bit_r == $past(sum[8]))
		else $error("carry wrong after add");
	a_half_add: assert property (
		do_op && is_add |=> half_carry_r == $past(hsum[4]))
		else $error("half carry wrong");
	a_wrap_div: assert property (
		do_op && op == core_status_pkg::OP_DIV
		|=> signed_wrap_flag_r == ($past(multiply_aux_operand_r) == 8'h00))
		else $error("divide wrap flag wrong");
	a_fetch_zero: assert property (
		fetch_start |-> fetch_pc == 16'h0000 && core_clk_en)
		else $error("fetch not from zero");
	a_idle_gating: assert property (
		state_r == core_status_pkg::ST_IDLE
		|-> !core_clk_en && periph_clk_en)
		else $error("idle gating wrong");
	a_bank_base: assert property (
		bank_base == {$past(bank_sel_hi_r), $past(bank_sel_lo_r), 3'b000})
		else $error("bank base wrong");
	c_enter_stop: cover property (@(posedge clk_sys) disable iff (rst)
		state_r == core_status_pkg::ST_STOP);
	c_enter_idle: cover property (@(posedge clk_sys) disable iff (rst)
		state_r == core_status_pkg::ST_IDLE);
	c_lost_reset: cover property (@(posedge clk_sys) disable iff (rst)
		lost_clock_reset);
	c_bit_write: cover property (@(posedge clk_sys) disable iff (rst)
		bit_write);

endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
`include "core_status_defines.svh"

module tb;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic lost_clock_detector = 1'b0, osc_alive = 1'b1;
	logic wb_ack_o, core_clk_en, periph_clk_en, osc_enable, baud_doubler;
	logic fetch_start, lost_clock_reset;
	logic [1:0] bank_sel;
	logic [4:0] bank_base;
	logic [15:0] fetch_pc;
	int err_total = 0, checks_done = 0, seed = 59;
	logic [7:0] acc_m = 8'h00, b_m = 8'h00, psw_m = 8'h00, v, ba;
	logic [7:0] mem_m [16];
	logic [31:0] rdat;
	int a, b, c, r, sa, sb, op, n;

	core_status_and_power_mode #(
		.LOST_CLOCK_CYCLES(20)
	) core_status_and_power_mode_inst (
		.clk_sys(clk_sys), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .lost_clock_detector(lost_clock_detector),
		.osc_alive(osc_alive), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
		.osc_enable(osc_enable), .baud_doubler(baud_doubler),
		.bank_sel(bank_sel), .bank_base(bank_base), .fetch_pc(fetch_pc),
		.fetch_start(fetch_start), .lost_clock_reset(lost_clock_reset)
	);

	always #2 clk_sys = ~clk_sys;

	// ==========================================
	// Checking and bus tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb_cycle(input logic we, input logic [7:0] idx,
		input logic [31:0] wd, input logic [3:0] sel);
		int k;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {22'h0, idx, 2'b00};
		wb_dat_i <= wd;
		wb_sel_i <= sel;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 50);
		chk(wb_ack_o, 1'b1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
		wb_cycle(1'b1, idx, wd, 4'hF);
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
		wb_cycle(1'b0, idx, 32'h0, 4'hF);
		chk(rdat, exp);
	endtask

	task automatic wait_fetch(input int lim);
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (fetch_start !== 1'b1 && k < lim);
		chk(fetch_start, 1'b1);
		chk(fetch_pc, 16'h0000);
	endtask

	function automatic logic [31:0] psw_exp();
		return {24'h0, psw_m[7:1], ^acc_m};
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		tally_and_finish();
	end

	// ==========================================
	// Scenarios
	initial begin
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		wait_fetch(40);
		rchk(`OFS_POWER_CONTROL, 32'h0);
		acc_m = $random(seed);
		wr(`OFS_MAIN_OPERAND, acc_m);
		rchk(`OFS_PROGRAM_STATUS, psw_exp());
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			wr(`OFS_POINTER_LOW, v);
			wr(`OFS_POINTER_HIGH, ~v);
			rchk(`OFS_POINTER_LOW, v);
			rchk(`OFS_POINTER_HIGH, {24'h0, ~v});
		end
		$display("pointer test done");
		for (int i = 0; i < 6; i++) begin
			v = $random(seed);
			v[0] = 1'b0;
			wr(`OFS_POWER_CONTROL, v);
			rchk(`OFS_POWER_CONTROL, v & 8'hFC);
			chk(baud_doubler, v[7]);
			chk(osc_enable, !v[1]);
			if (v[1]) begin
				rst <= 1'b1;
				repeat (2) @(posedge clk_sys);
				rst <= 1'b0;
				wait_fetch(40);
			end
		end
		wr(`OFS_POWER_CONTROL, 32'h7D);
		rchk(`OFS_POWER_CONTROL, 32'h7C);
		chk({core_clk_en, periph_clk_en, osc_enable}, 3'b011);
		rchk(`OFS_CORE_STATE, 32'h1);
		wr(`OFS_POWER_CONTROL, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk(core_clk_en, 1'b1);
		$display("power test done");
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			v[4:3] = 2'(i);
			psw_m = v;
			acc_m = $random(seed);
			// No bank register move follows the bank change
			wr(`OFS_PROGRAM_STATUS, v);
			wr(`OFS_MAIN_OPERAND, acc_m);
			rchk(`OFS_PROGRAM_STATUS, psw_exp());
			chk(bank_sel, i);
			chk(bank_base, i * 8);
		end
		$display("status test done");
		for (int i = 0; i < 35; i++) begin
			op = i % 7;
			acc_m = $random(seed);
			b_m = (i % 5 == 0) ? 8'h00 : 8'($random(seed));
			wr(`OFS_MAIN_OPERAND, acc_m);
			wr(`OFS_MULTIPLY_AUX, b_m);
			wr(`OFS_CORE_OP, op);
			a = acc_m;
			b = b_m;
			c = (op == 1) ? 0 : psw_m[7];
			sa = a > 127 ? a - 256 : a;
			sb = b > 127 ? b - 256 : b;
			if (op == 1 || op == 2) begin
				r = sa + sb + c;
				psw_m[7] = (a + b + c) > 255;
				psw_m[6] = (a % 16 + b % 16 + c) > 15;
				psw_m[2] = r > 127 || r < -128;
			end else if (op == 3) begin
				r = sa - sb - c;
				psw_m[7] = (a - b - c) < 0;
				psw_m[6] = (a % 16) < (b % 16 + c);
				psw_m[2] = r > 127 || r < -128;
			end else if (op != 0) begin
				psw_m[7:6] = 2'b00;
				if (op == 4) psw_m[2] = a * b > 255;
				if (op == 5) psw_m[2] = b == 0;
			end
			rchk(`OFS_PROGRAM_STATUS, psw_exp());
		end
		$display("arithmetic test done");
		for (int j = 0; j < 16; j++) begin
			mem_m[j] = $random(seed);
			wr(`BIT_BYTE_BASE + j, mem_m[j]);
		end
		for (int i = 0; i < 12; i++) begin
			ba = (i == 0) ? 8'h00 : (i == 1) ? 8'h07 : (i == 2) ? 8'h7F :
				8'($random(seed)) & 8'h7F;
			v = $random(seed) & 8'h01;
			wr(`OFS_BIT_ACCESS, {22'h0, v[0], 1'b1, 1'b1, ba[6:0]});
			mem_m[ba[6:3]][ba[2:0]] = v[0];
			rchk(`OFS_BIT_ACCESS, v[0]);
			wr(`BIT_BYTE_BASE + ba[6:3], 32'hA5);
			wr(`OFS_BIT_ACCESS, 32'h0);
			rchk(`BIT_BYTE_BASE + ba[6:3], mem_m[ba[6:3]]);
		end
		$display("bit window test done");
		wr(8'h10, 32'hFF);
		rchk(8'h10, 32'h0);
		wr(`OFS_POINTER_LOW, 32'h3C);
		wb_cycle(1'b1, `OFS_POINTER_LOW, 32'hC3, 4'hE);
		rchk(`OFS_POINTER_LOW, 32'h3C);
		$display("refusal test done");
		osc_alive <= 1'b0;
		// Detector off, no analog parts on, before stop
		wr(`OFS_POWER_CONTROL, 32'h02);
		repeat (3) @(posedge clk_sys);
		chk({core_clk_en, periph_clk_en, osc_enable}, 3'b000);
		n = 0;
		repeat (60) begin
			@(posedge clk_sys);
			n += (lost_clock_reset !== 1'b0) || (fetch_start !== 1'b0);
		end
		chk(n, 0);
		chk(osc_enable, 1'b0);
		lost_clock_detector <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (lost_clock_reset !== 1'b1 && n < 60);
		chk(lost_clock_reset, 1'b1);
		osc_alive <= 1'b1;
		lost_clock_detector <= 1'b0;
		wait_fetch(40);
		repeat (2) @(posedge clk_sys);
		chk({core_clk_en, osc_enable}, 2'b11);
		wr(`OFS_POWER_CONTROL, 32'h82);
		repeat (3) @(posedge clk_sys);
		chk(osc_enable, 1'b0);
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		wait_fetch(40);
		rchk(`OFS_POWER_CONTROL, 32'h0);
		chk(baud_doubler, 1'b0);
		$display("stop test done");
		tally_and_finish();
	end
endmodule
